/* logic/field32_pkg.sv */
/*
 * Constants, types and the encoding decode function for the 32-bit
 * field store of the virtual-machine control structure.
 * Assumes a single core clock and software as the only requester.
 */
package field32_pkg;

	// ------------------------------------------------------------
	// Encoding layout
	// ------------------------------------------------------------
	localparam int ENC_WIDTH_LSB = 13;
	localparam int ENC_TYPE_LSB = 10;
	localparam int ENC_INDEX_LSB = 1;
	localparam logic [1:0] WIDTH_CLASS_32 = 2'h2;

	typedef enum logic [1:0] {
		FT_CTRL = 2'h0,
		FT_EXIT = 2'h1,
		FT_GUEST = 2'h2,
		FT_HOST = 2'h3
	} field_type_e;

	// ------------------------------------------------------------
	// Storage layout: one flat slot array for all four types
	// ------------------------------------------------------------
	localparam int SLOT_W = 6;
	localparam logic [8:0] CTRL_COUNT = 9'h012;
	localparam logic [8:0] EXIT_COUNT = 9'h008;
	localparam logic [8:0] GUEST_COUNT = 9'h018;
	localparam logic [8:0] HOST_COUNT = 9'h001;
	localparam logic [SLOT_W-1:0] CTRL_BASE = 6'h00;
	localparam logic [SLOT_W-1:0] EXIT_BASE = 6'h12;
	localparam logic [SLOT_W-1:0] GUEST_BASE = 6'h1a;
	localparam logic [SLOT_W-1:0] HOST_BASE = 6'h32;
	localparam int NUM_SLOTS = 51;

	// Optional fields, the guest hole and the descriptor-table limits, by index within their type
	localparam logic [8:0] IDX_TASK_PRIORITY = 9'h00e;
	localparam logic [8:0] IDX_SECONDARY = 9'h00f;
	localparam logic [8:0] IDX_PAUSE_LOOP_GAP = 9'h010;
	localparam logic [8:0] IDX_PAUSE_LOOP_WINDOW = 9'h011;
	localparam logic [8:0] IDX_GUEST_HOLE = 9'h016;
	localparam logic [8:0] IDX_PREEMPT_TIMER = 9'h017;
	localparam logic [8:0] IDX_GDT_LIMIT = 9'h008;
	localparam logic [8:0] IDX_IDT_LIMIT = 9'h009;

	// Capability bits
	localparam int CAP_TASK_PRIORITY = 0;
	localparam int CAP_SECONDARY = 1;
	localparam int CAP_PAUSE_LOOP = 2;
	localparam int CAP_PREEMPT_TIMER = 3;
	localparam logic [3:0] CAPS_RESET = 4'hf;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [31:0] OFS_ENCODING = 32'h0000_0000;
	localparam logic [31:0] OFS_WDATA = 32'h0000_0004;
	localparam logic [31:0] OFS_COMMAND = 32'h0000_0008;
	localparam logic [31:0] OFS_RDATA = 32'h0000_000c;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0010;
	localparam logic [31:0] OFS_MASK = 32'h0000_0014;
	localparam logic [31:0] OFS_CAPS = 32'h0000_0018;
	localparam logic [31:0] OFS_DECODE = 32'h0000_001c;

	localparam int CMD_READ = 0;
	localparam int CMD_WRITE = 1;

	localparam int ST_DONE = 0;
	localparam int ST_INVALID = 1;
	localparam int ST_RO_REJECT = 2;
	localparam int ST_ENTRY = 3;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [0:0] {
		CH_IDLE = 1'h0,
		CH_RESP = 1'h1
	} chan_state_e;

	typedef struct packed {
		logic valid;
		logic read_only;
		field_type_e ftype;
		logic [8:0] index;
		logic [SLOT_W-1:0] slot;
	} decode_s;

	// ------------------------------------------------------------
	// Encoding decode
	// ------------------------------------------------------------
	function automatic decode_s decode_enc(input logic [31:0] enc, input logic [3:0] caps);
		decode_s d;
		logic ok;
		d.ftype = field_type_e'(enc[ENC_TYPE_LSB +: 2]);
		d.index = enc[ENC_INDEX_LSB +: 9];
		d.read_only = (d.ftype == FT_EXIT);
		ok = (enc[31:15] == 17'h0_0000) && (enc[12] == 1'b0);
		ok = ok && (enc[ENC_WIDTH_LSB +: 2] == WIDTH_CLASS_32);
		ok = ok && (enc[0] == 1'b0);
		d.slot = '0;
		case (d.ftype)
			FT_CTRL:
			begin
				ok = ok && (d.index < CTRL_COUNT);
				if (d.index == IDX_TASK_PRIORITY)
					ok = ok && caps[CAP_TASK_PRIORITY];
				if (d.index == IDX_SECONDARY)
					ok = ok && caps[CAP_SECONDARY];
				if (d.index == IDX_PAUSE_LOOP_GAP || d.index == IDX_PAUSE_LOOP_WINDOW)
					ok = ok && caps[CAP_PAUSE_LOOP];
				d.slot = CTRL_BASE + d.index[SLOT_W-1:0];
			end
			FT_EXIT:
			begin
				ok = ok && (d.index < EXIT_COUNT);
				d.slot = EXIT_BASE + d.index[SLOT_W-1:0];
			end
			FT_GUEST:
			begin
				ok = ok && (d.index < GUEST_COUNT) && (d.index != IDX_GUEST_HOLE);
				if (d.index == IDX_PREEMPT_TIMER)
					ok = ok && caps[CAP_PREEMPT_TIMER];
				d.slot = GUEST_BASE + d.index[SLOT_W-1:0];
			end
			FT_HOST:
			begin
				ok = ok && (d.index < HOST_COUNT);
				d.slot = HOST_BASE + d.index[SLOT_W-1:0];
			end
			default:
			begin
				ok = 1'b0;
			end
		endcase
		d.valid = ok;
		return d;
	endfunction : decode_enc

endpackage : field32_pkg

/* logic/field32_decoder.sv */
/*
 * 32-bit field store with encoding decoder, reached over AXI4-Lite.
 * Assumes a single 100 MHz core clock, synchronous active-high reset,
 * and a core that pulses VM_ENTRY and loads exit data on its own port.
 */
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [RULE_01] Bits 14:13 equal to 2 mark a 32-bit field encoding.
// [RULE_02] 32-bit fields take full access only; bit 0 must be zero.
// [RULE_03] Type bits 11:10 equal to 0 select a control field.
// [RULE_04] Type 1 selects read-only exit data software cannot write.
// [RULE_05] Type 2 selects a guest-state field.
// [RULE_06] Type 3 selects a host-state field.
// [RULE_07] Bits 9:1 pick the field within its width class and type.
// [RULE_08] Control fields run 4000h to 4022h in even steps.
// [RULE_09] Exit data fields run 4400h to 440Eh in even steps.
// [RULE_10] Guest fields 4800h to 482Ah, preemption timer at 482Eh.
// [RULE_11] The single host field sits at 4C00h.
// [RULE_12] Task-priority threshold exists only with its shadow control supported.
// [RULE_13] Secondary controls exist only with activate-secondary supported.
// [RULE_14] Pause-loop gap and window exist only with pause-loop exiting supported.
// [RULE_15] Preemption timer value exists only with the timer control supported.
// [RULE_16] Each entry clears the upper 16 bits of both descriptor-table limits.
// [RULE_17] Odd, unlisted or unsupported encodings report invalid and touch nothing.
// [RULE_18] Writes to exit data are rejected and storage stays unchanged.
module field32_decoder (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// AXI4-Lite write address
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] AWADDR,
	input wire logic [2:0] AWPROT,
	// AXI4-Lite write data
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	// AXI4-Lite write response
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// AXI4-Lite read address
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [31:0] ARADDR,
	input wire logic [2:0] ARPROT,
	// AXI4-Lite read data
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// Core side
	input wire logic VM_ENTRY,
	input wire logic EXIT_WR,
	input wire logic [2:0] EXIT_INDEX,
	input wire logic [31:0] EXIT_DATA,
	// Interrupt
	output logic IRQ
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [31:0] fields_r [0:field32_pkg::NUM_SLOTS-1];
	logic [31:0] enc_r;
	logic [31:0] wdata_r;
	logic [31:0] rdata_field_r;
	logic [3:0] status_r;
	logic [3:0] mask_r;
	logic [3:0] caps_r;
	logic [31:0] awaddr_r;
	logic [31:0] wbuf_r;
	logic [3:0] wstrb_r;
	logic aw_got_r;
	logic w_got_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic irq_r;
	field32_pkg::chan_state_e wr_state_r;
	field32_pkg::chan_state_e rd_state_r;
	field32_pkg::decode_s dec;
	logic wr_fire;
	logic wr_mapped;
	logic cmd_fire;
	logic do_read;
	logic do_write;
	logic [31:0] wr_val;
	logic [3:0] status_set;
	logic [3:0] status_clr;
	logic [3:0] status_nxt;
	logic [31:0] rd_val;
	logic rd_mapped;
	logic [field32_pkg::SLOT_W-1:0] exit_slot;
	logic [field32_pkg::SLOT_W-1:0] gdt_slot;
	logic [field32_pkg::SLOT_W-1:0] idt_slot;

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		end
		return r;
	endfunction : merge_strb

	// ------------------------------------------------------------
	// Encoding decode and command qualification
	// ------------------------------------------------------------
	// Width class, type, index and gating [RULE_01] [RULE_03] [RULE_04] [RULE_05] [RULE_06]
	// Index ranges per type [RULE_07] [RULE_08] [RULE_09] [RULE_10] [RULE_11]
	// Optional fields by capability [RULE_12] [RULE_13] [RULE_14] [RULE_15]
	always_comb
	begin
		dec = field32_pkg::decode_enc(enc_r, caps_r); // [RULE_02] [RULE_17]
	end

	assign wr_fire = aw_got_r && w_got_r && (wr_state_r == field32_pkg::CH_IDLE);
	assign wr_mapped = (awaddr_r[31:5] == 27'h0) && (awaddr_r[1:0] == 2'h0);
	assign wr_val = merge_strb(32'h0, wbuf_r, wstrb_r);
	assign cmd_fire = wr_fire && (awaddr_r == field32_pkg::OFS_COMMAND);
	// Invalid encodings never reach storage [RULE_17]
	assign do_read = cmd_fire && wr_val[field32_pkg::CMD_READ] && dec.valid;
	// Exit data is never written by software [RULE_18]
	assign do_write = cmd_fire && wr_val[field32_pkg::CMD_WRITE] && dec.valid
		&& !dec.read_only;

	assign exit_slot = field32_pkg::EXIT_BASE + {3'h0, EXIT_INDEX};
	assign gdt_slot = field32_pkg::GUEST_BASE + field32_pkg::IDX_GDT_LIMIT[5:0];
	assign idt_slot = field32_pkg::GUEST_BASE + field32_pkg::IDX_IDT_LIMIT[5:0];

	// ------------------------------------------------------------
	// Field storage
	// ------------------------------------------------------------
	// No reset on the array: contents are undefined until loaded, as for RAM
	always_ff @(posedge CLK)
	begin
		if (do_write)
			fields_r[dec.slot] <= wdata_r;
		if (EXIT_WR)
			fields_r[exit_slot] <= EXIT_DATA;
		if (VM_ENTRY)
		begin
			// Only 16 limit bits are real; entry scrubs the rest [RULE_16]
			fields_r[gdt_slot][31:16] <= 16'h0000;
			fields_r[idt_slot][31:16] <= 16'h0000;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			rdata_field_r <= 32'h0;
		else if (do_read)
			rdata_field_r <= fields_r[dec.slot];
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			enc_r <= 32'h0;
			wdata_r <= 32'h0;
			mask_r <= field32_pkg::MASK_RESET;
			caps_r <= field32_pkg::CAPS_RESET;
		end
		else if (wr_fire)
		begin
			case (awaddr_r)
				field32_pkg::OFS_ENCODING:
					enc_r <= merge_strb(enc_r, wbuf_r, wstrb_r);
				field32_pkg::OFS_WDATA:
					wdata_r <= merge_strb(wdata_r, wbuf_r, wstrb_r);
				field32_pkg::OFS_MASK:
					mask_r <= wr_val[3:0] | (mask_r & ~{4{wstrb_r[0]}});
				field32_pkg::OFS_CAPS:
					caps_r <= wr_val[3:0] | (caps_r & ~{4{wstrb_r[0]}});
				default:
				begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Status and interrupt
	// ------------------------------------------------------------
	always_comb
	begin
		status_set = 4'h0;
		status_set[field32_pkg::ST_DONE] = do_read || do_write;
		status_set[field32_pkg::ST_INVALID] = cmd_fire && !dec.valid
			&& (wr_val[field32_pkg::CMD_READ] || wr_val[field32_pkg::CMD_WRITE]); // [RULE_17]
		status_set[field32_pkg::ST_RO_REJECT] = cmd_fire && dec.valid && dec.read_only
			&& wr_val[field32_pkg::CMD_WRITE]; // [RULE_18]
		status_set[field32_pkg::ST_ENTRY] = VM_ENTRY;
		status_clr = (wr_fire && awaddr_r == field32_pkg::OFS_STATUS) ? wr_val[3:0] : 4'h0;
		// A new event beats a clear in the same cycle
		status_nxt = (status_r & ~status_clr) | status_set;
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			status_r <= field32_pkg::STATUS_RESET;
		else
			status_r <= status_nxt;
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_nxt & mask_r);
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			awaddr_r <= 32'h0;
			wbuf_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= field32_pkg::RESP_OKAY;
			wr_state_r <= field32_pkg::CH_IDLE;
		end
		else
		begin
			if (AWVALID && awready_r)
			begin
				awaddr_r <= AWADDR;
				aw_got_r <= 1'b1;
				awready_r <= 1'b0;
			end
			if (WVALID && wready_r)
			begin
				wbuf_r <= WDATA;
				wstrb_r <= WSTRB;
				w_got_r <= 1'b1;
				wready_r <= 1'b0;
			end
			case (wr_state_r)
				field32_pkg::CH_IDLE:
				begin
					if (wr_fire)
					begin
						bvalid_r <= 1'b1;
						bresp_r <= wr_mapped ? field32_pkg::RESP_OKAY
							: field32_pkg::RESP_DECERR;
						wr_state_r <= field32_pkg::CH_RESP;
					end
				end
				field32_pkg::CH_RESP:
				begin
					if (BREADY)
					begin
						bvalid_r <= 1'b0;
						aw_got_r <= 1'b0;
						w_got_r <= 1'b0;
						awready_r <= 1'b1;
						wready_r <= 1'b1;
						wr_state_r <= field32_pkg::CH_IDLE;
					end
				end
				default:
					wr_state_r <= field32_pkg::CH_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always_comb
	begin
		rd_mapped = 1'b1;
		case (ARADDR)
			field32_pkg::OFS_ENCODING:
				rd_val = enc_r;
			field32_pkg::OFS_WDATA:
				rd_val = wdata_r;
			field32_pkg::OFS_COMMAND:
				rd_val = 32'h0;
			field32_pkg::OFS_RDATA:
				rd_val = rdata_field_r;
			field32_pkg::OFS_STATUS:
				rd_val = {28'h0, status_r};
			field32_pkg::OFS_MASK:
				rd_val = {28'h0, mask_r};
			field32_pkg::OFS_CAPS:
				rd_val = {28'h0, caps_r};
			field32_pkg::OFS_DECODE:
				rd_val = {12'h0, dec.slot, 1'b0, dec.index, dec.ftype, dec.read_only, dec.valid};
			default:
			begin
				rd_val = 32'h0;
				rd_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= field32_pkg::RESP_OKAY;
			rd_state_r <= field32_pkg::CH_IDLE;
		end
		else
		begin
			case (rd_state_r)
				field32_pkg::CH_IDLE:
				begin
					if (ARVALID)
					begin
						arready_r <= 1'b0;
						rvalid_r <= 1'b1;
						rdata_r <= rd_val;
						rresp_r <= rd_mapped ? field32_pkg::RESP_OKAY
							: field32_pkg::RESP_DECERR;
						rd_state_r <= field32_pkg::CH_RESP;
					end
				end
				field32_pkg::CH_RESP:
				begin
					if (RREADY)
					begin
						rvalid_r <= 1'b0;
						arready_r <= 1'b1;
						rd_state_r <= field32_pkg::CH_IDLE;
					end
				end
				default:
					rd_state_r <= field32_pkg::CH_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign AWREADY = awready_r;
	assign WREADY = wready_r;
	assign BVALID = bvalid_r;
	assign BRESP = bresp_r;
	assign ARREADY = arready_r;
	assign RVALID = rvalid_r;
	assign RDATA = rdata_r;
	assign RRESP = rresp_r;
	assign IRQ = irq_r;

endmodule : field32_decoder

`default_nettype wire

/* tb/field32_decoder_sva.sv */
/*
 * Port checker for the 32-bit field decoder.
 * Assumes it is bound to field32_decoder and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module field32_decoder_sva (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Write channels
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [31:0] AWADDR,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP,
	// Read channels
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] ARADDR,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic [31:0] RDATA,
	// Interrupt
	input wire logic IRQ
);
	// --------------------------------
	// Shadow of the encoding register
	// --------------------------------
	logic [31:0] aw_addr_r, w_data_r, enc_r;
	logic [3:0] w_strb_r;
	logic bvalid_r, rd_dec_r;

	always_ff @(posedge CLK)
	begin
		if (AWVALID && AWREADY)
			aw_addr_r <= AWADDR;
		if (WVALID && WREADY)
		begin
			w_data_r <= WDATA;
			w_strb_r <= WSTRB;
		end
		if (ARVALID && ARREADY)
			rd_dec_r <= (ARADDR == field32_pkg::OFS_DECODE);
	end

	// Follows one edge late; reads only start after the write response
	always_ff @(posedge CLK)
	begin
		bvalid_r <= BVALID;
		if (SYS_RST)
			enc_r <= 32'h0;
		else if (BVALID && !bvalid_r && BRESP == field32_pkg::RESP_OKAY
			&& aw_addr_r == field32_pkg::OFS_ENCODING)
			for (int i = 0; i < 4; i++)
				if (w_strb_r[i])
					enc_r[8*i +: 8] <= w_data_r[8*i +: 8];
	end

	// --------------------------------
	// Assertions
	// --------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	chk_bresp_hold:
	assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	chk_rdata_hold:
	assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped early");
	chk_write_answer:
	assert property (AWVALID && AWREADY && WVALID && WREADY |-> !BVALID ##2 BVALID)
		else $error("write response not on time");
	chk_read_answer:
	assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read data not on time");
	chk_decerr_write:
	assert property (AWVALID && AWREADY && WVALID && WREADY && AWADDR > 32'h1c
		|-> ##2 BRESP == field32_pkg::RESP_DECERR)
		else $error("unmapped write not refused");
	chk_decode_type:
	assert property ($rose(RVALID) && rd_dec_r |-> RDATA[3:2] == enc_r[11:10])
		else $error("decoded type wrong");
	chk_decode_index:
	assert property ($rose(RVALID) && rd_dec_r |-> RDATA[12:4] == enc_r[9:1])
		else $error("decoded index wrong");
	chk_exit_readonly:
	assert property ($rose(RVALID) && rd_dec_r |-> RDATA[1] == (enc_r[11:10] == 2'h1))
		else $error("read-only flag wrong");
	chk_odd_invalid:
	assert property ($rose(RVALID) && rd_dec_r && enc_r[0] |-> !RDATA[0])
		else $error("odd encoding accepted");
	chk_class_invalid:
	assert property ($rose(RVALID) && rd_dec_r && enc_r[14:13] != 2'h2 |-> !RDATA[0])
		else $error("wrong width class accepted");
	chk_irq_reset:
	assert property ($past(SYS_RST) |-> !IRQ)
		else $error("interrupt high out of reset");
endmodule : field32_decoder_sva
`default_nettype wire

/* tb/field32_decoder_test.sv */
/*
 * Self-checking bench for the 32-bit field decoder.
 * Assumes the package constants and one 100 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module field32_decoder_test;
	logic CLK = 1'b0, SYS_RST = 1'b1, VM_ENTRY = 1'b0, EXIT_WR = 1'b0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
	logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, EXIT_DATA = 32'h0;
	logic [31:0] RDATA, rd, sw, dw;
	logic [3:0] WSTRB = 4'hf;
	logic [2:0] EXIT_INDEX = 3'h0;
	logic [1:0] BRESP, RRESP, rs;
	int mismatches = 0;
	int n_checks = 0;

	always #5 CLK = ~CLK;

	field32_decoder dut (.CLK(CLK), .SYS_RST(SYS_RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
		.WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY),
		.RDATA(RDATA), .RRESP(RRESP), .VM_ENTRY(VM_ENTRY), .EXIT_WR(EXIT_WR),
		.EXIT_INDEX(EXIT_INDEX), .EXIT_DATA(EXIT_DATA), .IRQ(IRQ));

	// --------------------------------
	// Verdict and comparison
	// --------------------------------
	task automatic summarize;
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic hang;
		mismatches++;
		$display("[ERR] %0t bus gave no answer", $time);
		summarize();
	endtask : hang

	// --------------------------------
	// Bus cycles
	// --------------------------------
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge CLK);
			if (AWVALID && AWREADY === 1'b1)
				AWVALID <= 1'b0;
			if (WVALID && WREADY === 1'b1)
				WVALID <= 1'b0;
			if (BVALID === 1'b1)
				break;
		end
		if (n == 40)
			hang();
		r = BRESP;
		BREADY <= 1'b0;
		// Let an edge pass so a following call never re-drives BREADY in this step
		@(posedge CLK);
	endtask : wr

	task automatic rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge CLK);
			if (ARVALID && ARREADY === 1'b1)
				ARVALID <= 1'b0;
			if (RVALID === 1'b1)
				break;
		end
		if (n == 40)
			hang();
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
		@(posedge CLK);
	endtask : rdr

	// Field command, then result, status and a status clear
	task automatic fop(input logic [31:0] enc, input logic [1:0] cmd, input logic [31:0] wd);
		wr(field32_pkg::OFS_ENCODING, enc, rs);
		wr(field32_pkg::OFS_WDATA, wd, rs);
		wr(field32_pkg::OFS_COMMAND, {30'h0, cmd}, rs);
		rdr(field32_pkg::OFS_RDATA, rd, rs);
		rdr(field32_pkg::OFS_STATUS, sw, rs);
		rdr(field32_pkg::OFS_DECODE, dw, rs);
		wr(field32_pkg::OFS_STATUS, 32'hf, rs);
	endtask : fop

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic s_regs;
		rdr(field32_pkg::OFS_CAPS, rd, rs);
		check(rd, 32'hf);
		rdr(field32_pkg::OFS_MASK, rd, rs);
		check(rd, 32'h0);
		rdr(32'h20, rd, rs);
		check({rd[29:0], rs}, 32'h3);
		wr(32'h22, 32'h1, rs);
		check({30'h0, rs}, 32'h3);
	endtask : s_regs

	task automatic s_map;
		logic [31:0] e[$];
		for (int i = 0; i < 18; i++)
			e.push_back(32'h4000 + 2 * i);
		for (int i = 0; i < 22; i++)
			e.push_back(32'h4800 + 2 * i);
		e.push_back(32'h482e);
		e.push_back(32'h4c00);
		foreach (e[i])
		begin
			fop(e[i], 2'h2, ~e[i]);
			check(sw, 32'h1);
			check({23'h0, dw[12:4]}, {23'h0, e[i][9:1]});
		end
		foreach (e[i])
		begin
			fop(e[i], 2'h1, 32'h0);
			check(rd, ~e[i]);
		end
	endtask : s_map

	task automatic s_invalid;
		logic [31:0] bad[10] = '{32'h4001, 32'h4024, 32'h4410, 32'h482c, 32'h4830,
			32'h4c02, 32'h2000, 32'h6000, 32'h14000, 32'h5000};
		fop(32'h4000, 2'h2, 32'h1111_2222);
		fop(32'h4000, 2'h1, 32'h0);
		foreach (bad[i])
		begin
			fop(bad[i], 2'h3, 32'hdead_beef);
			check(sw, 32'h2);
			check(rd, 32'h1111_2222);
			check({31'h0, dw[0]}, 32'h0);
		end
		fop(32'h4000, 2'h1, 32'h0);
		check(rd, 32'h1111_2222);
	endtask : s_invalid

	task automatic s_exit;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge CLK);
			EXIT_WR <= 1'b1;
			EXIT_INDEX <= 3'(i);
			EXIT_DATA <= 32'hc0de_0000 + i;
		end
		@(posedge CLK);
		EXIT_WR <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			fop(32'h4400 + 2 * i, 2'h1, 32'h0);
			check(rd, 32'hc0de_0000 + i);
		end
		fop(32'h4402, 2'h2, 32'h0bad_0bad);
		check(sw, 32'h4);
		fop(32'h4402, 2'h1, 32'h0);
		check(rd, 32'hc0de_0001);
	endtask : s_exit

	task automatic s_caps;
		logic [31:0] oe[5] = '{32'h401c, 32'h401e, 32'h4020, 32'h4022, 32'h482e};
		int cb[5] = '{field32_pkg::CAP_TASK_PRIORITY, field32_pkg::CAP_SECONDARY,
			field32_pkg::CAP_PAUSE_LOOP, field32_pkg::CAP_PAUSE_LOOP,
			field32_pkg::CAP_PREEMPT_TIMER};
		for (int k = 0; k < 4; k++)
		begin
			wr(field32_pkg::OFS_CAPS, 32'hf ^ (32'h1 << k), rs);
			foreach (oe[j])
			begin
				fop(oe[j], 2'h1, 32'h0);
				check(sw, cb[j] == k ? 32'h2 : 32'h1);
			end
		end
		wr(field32_pkg::OFS_CAPS, 32'hf, rs);
	endtask : s_caps

	task automatic s_entry;
		fop(32'h4810, 2'h2, 32'habcd_1234);
		fop(32'h4812, 2'h2, 32'hffff_5678);
		fop(32'h4814, 2'h2, 32'h8765_4321);
		@(posedge CLK);
		VM_ENTRY <= 1'b1;
		@(posedge CLK);
		VM_ENTRY <= 1'b0;
		repeat (3) @(posedge CLK);
		check({31'h0, IRQ}, 32'h0);
		rdr(field32_pkg::OFS_STATUS, rd, rs);
		check(rd, 32'h8);
		wr(field32_pkg::OFS_MASK, 32'h8, rs);
		repeat (3) @(posedge CLK);
		check({31'h0, IRQ}, 32'h1);
		wr(field32_pkg::OFS_STATUS, 32'h8, rs);
		repeat (3) @(posedge CLK);
		check({31'h0, IRQ}, 32'h0);
		wr(field32_pkg::OFS_MASK, 32'h0, rs);
		fop(32'h4810, 2'h1, 32'h0);
		check(rd, 32'h0000_1234);
		fop(32'h4812, 2'h1, 32'h0);
		check(rd, 32'h0000_5678);
		fop(32'h4814, 2'h1, 32'h0);
		check(rd, 32'h8765_4321);
	endtask : s_entry

	initial
	begin
		repeat (12) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		s_regs();
		s_map();
		s_invalid();
		s_exit();
		s_caps();
		s_entry();
		summarize();
	end
endmodule : field32_decoder_test

bind field32_decoder field32_decoder_sva sva (.CLK(CLK), .SYS_RST(SYS_RST),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID),
	.WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
	.BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
	.RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .IRQ(IRQ));
`default_nettype wire
